/* src/clockgen_defines.svh */
// Purpose: constants of the device control and status register bank
// Assumes: 125 MHz core clock, 8-bit register port behind the serial target
// Notes: included by the clockgen_ctl module of the bank only
`ifndef CLOCKGEN_DEFINES_SVH
`define CLOCKGEN_DEFINES_SVH

`define CLK_PERIOD_NS    8
`define ALIGN_TIME_NS    64
`define ALIGN_CYCLES     ((`ALIGN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define IDX_TARGET_ADDR  8'h0a
`define IDX_IMAGE_REV    8'h0b
`define IDX_DEVICE_CONTROL      8'h0c
`define IDX_LIVE_STATUS  8'h0d

`define TARGET_ADDR_RST  8'h54
`define IMAGE_REV_RST    8'h00
`define DEVICE_CONTROL_RST      8'hd9
`define DEVICE_CONTROL_WMASK    8'hdf

`define CTL_SOFT_RESET   7
`define CTL_SOFT_ALIGN   6
`define CTL_AUTO_ALIGN   4
`define CTL_ALIGN_MUTE   3
`define CTL_KEEP_BACKUP  2
`define CTL_CAL_ORDER    1
`define CTL_AUTO_LOCK    0

`define STRAP_IN_MID     2'h1
`define STRAP_IN_HIGH    2'h2
`define STRAP_BITS_LOW   2'h0
`define STRAP_BITS_MID   2'h1
`define STRAP_BITS_HIGH  2'h3
`define STRAP_SETTLE     2'h2

`endif

/* src/clockgen_pkg.sv */
// Purpose: shared types of the device control and status bank
// Assumes: nothing
// Notes: constants live in clockgen_defines.svh
package clockgen_pkg;
	typedef enum logic [1:0] {seq_wait, seq_locking, seq_align, seq_run} seq_state_e;
	typedef logic [7:0] reg_byte_t;
endpackage

/* src/pll_monitor.sv */
// Purpose: live condition of one PLL: calibrating, lock lost, input lost, back to main ref
// Assumes: raw status comes from analog/other domains and is synchronised here
// Notes: restart_i clears calibration state synchronously
`timescale 1ns/1ns
module pll_monitor
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic restart_i,
	// control
	input  wire logic cal_start_i,
	// raw status
	input  wire logic lock_raw_i,
	input  wire logic input_ok_raw_i,
	input  wire logic cal_done_raw_i,
	input  wire logic back_main_raw_i,
	// live conditions
	output logic      locked_o,
	output logic      calibrating_o,
	output logic      lock_lost_o,
	output logic      input_lost_o,
	output logic      back_main_o
);
	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic       started_reg;

	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_reg <= 4'h0;
			sync_reg <= 4'h0;
		end
		else
		begin
			meta_reg <= {back_main_raw_i, cal_done_raw_i, input_ok_raw_i, lock_raw_i};
			sync_reg <= meta_reg;
		end
	end

	// ----------------------------------------
	// calibration tracking, start wins over done
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			calibrating_o <= 1'b0;
			started_reg   <= 1'b0;
		end
		else if (restart_i)
		begin
			calibrating_o <= 1'b0;
			started_reg   <= 1'b0;
		end
		else
		begin
			calibrating_o <= cal_start_i | (calibrating_o & ~sync_reg[2]);
			started_reg   <= started_reg | cal_start_i;
		end
	end

	// ----------------------------------------
	// live conditions, input loss takes precedence
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			locked_o     <= 1'b0;
			lock_lost_o  <= 1'b0;
			input_lost_o <= 1'b0;
			back_main_o  <= 1'b0;
		end
		else
		begin
			locked_o     <= started_reg & ~calibrating_o & sync_reg[0];
			lock_lost_o  <= started_reg & ~calibrating_o & ~sync_reg[0] & sync_reg[1];
			input_lost_o <= ~sync_reg[1];
			back_main_o  <= sync_reg[3];
		end
	end
endmodule

/* src/clockgen_ctl.sv */
// Purpose: device control/status registers and startup sequencer of a two-PLL clock generator
// Assumes: register port driven by the serial target logic on clk_i
// Notes: soft reset holds the sequencer and monitors while control bit 7 is low
`timescale 1ns/1ns
`include "clockgen_defines.svh"
module clockgen_ctl
	import clockgen_pkg::*;
#(
	parameter int ALIGN_LEN = `ALIGN_CYCLES
)
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// nonvolatile image
	input  wire logic       nv_commit_i,
	input  wire logic       nv_valid_i,
	input  wire logic [4:0] nv_addr_hi_i,
	input  wire logic [7:0] nv_rev_i,
	output logic            nv_fetch_o,
	// pins
	input  wire logic       align_pin_n_i,
	input  wire logic [1:0] strap_level_i,
	// pll a status
	input  wire logic       pll_a_lock_i,
	input  wire logic       pll_a_input_ok_i,
	input  wire logic       pll_a_cal_done_i,
	input  wire logic       pll_a_back_main_i,
	input  wire logic       pll_a_power_down_i,
	// pll b status
	input  wire logic       pll_b_lock_i,
	input  wire logic       pll_b_input_ok_i,
	input  wire logic       pll_b_cal_done_i,
	input  wire logic       pll_b_back_main_i,
	input  wire logic       pll_b_power_down_i,
	// interrupt flag side
	input  wire logic [7:0] flag_polarity_i,
	output logic      [7:0] flag_set_o,
	// core control
	output logic            core_reset_o,
	output logic            cal_start_a_o,
	output logic            cal_start_b_o,
	output logic            sysclk_vco_o,
	output logic            drive_enable_o,
	output logic            align_active_o
);
	reg_byte_t  target_addr_reg;
	reg_byte_t  image_rev_reg;
	reg_byte_t  ctl_reg;
	reg_byte_t  live_reg;
	reg_byte_t  live_prev_reg;
	seq_state_e seq_state;
	logic [3:0] align_cnt_reg;
	logic [1:0] strap_meta_reg;
	logic [1:0] strap_s_reg;
	logic [1:0] strap_wait_reg;
	logic       strap_cap_reg;
	logic       align_meta_reg;
	logic       align_s_reg;
	logic       boot_reg;
	logic       b_started_reg;
	logic       b_pd_prev_reg;
	logic       a_locked;
	logic       a_cal;
	logic       a_lol;
	logic       a_los;
	logic       a_back;
	logic       b_locked;
	logic       b_cal;
	logic       b_lol;
	logic       b_los;
	logic       b_back;
	logic       soft_hold;
	logic       ctl_wr;
	logic       auto_rise;
	logic       start_go;
	logic       a_ready;
	logic       both_ready;
	logic       b_go;
	logic       b_restart;
	logic       align_any;
	logic [1:0] strap_bits;

	assign soft_hold  = ~ctl_reg[`CTL_SOFT_RESET];
	assign ctl_wr     = reg_wr_i & (reg_addr_i == `IDX_DEVICE_CONTROL);
	assign auto_rise  = ctl_wr & reg_wdata_i[`CTL_AUTO_LOCK] & ~ctl_reg[`CTL_AUTO_LOCK];
	assign start_go   = (seq_state == seq_wait) & ((boot_reg & ctl_reg[`CTL_AUTO_LOCK]) | auto_rise);
	assign a_ready    = a_locked | pll_a_power_down_i;
	assign both_ready = a_ready & (b_locked | pll_b_power_down_i) & b_started_reg;
	assign b_go       = (seq_state == seq_locking) & ~b_started_reg & ~cal_start_a_o
	                    & (ctl_reg[`CTL_CAL_ORDER] | a_ready);
	assign b_restart  = ctl_reg[`CTL_CAL_ORDER] & b_pd_prev_reg & ~pll_b_power_down_i
	                    & (seq_state != seq_wait);
	assign align_any  = (seq_state == seq_align) | ~align_s_reg | ~ctl_reg[`CTL_SOFT_ALIGN];

	// ----------------------------------------
	// per-PLL monitors
	// ----------------------------------------
	pll_monitor u_mon_a
	(
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.restart_i      (soft_hold),
		.cal_start_i    (cal_start_a_o),
		.lock_raw_i     (pll_a_lock_i),
		.input_ok_raw_i (pll_a_input_ok_i),
		.cal_done_raw_i (pll_a_cal_done_i),
		.back_main_raw_i(pll_a_back_main_i),
		.locked_o       (a_locked),
		.calibrating_o  (a_cal),
		.lock_lost_o    (a_lol),
		.input_lost_o   (a_los),
		.back_main_o    (a_back)
	);

	pll_monitor u_mon_b
	(
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.restart_i      (soft_hold),
		.cal_start_i    (cal_start_b_o),
		.lock_raw_i     (pll_b_lock_i),
		.input_ok_raw_i (pll_b_input_ok_i),
		.cal_done_raw_i (pll_b_cal_done_i),
		.back_main_raw_i(pll_b_back_main_i),
		.locked_o       (b_locked),
		.calibrating_o  (b_cal),
		.lock_lost_o    (b_lol),
		.input_lost_o   (b_los),
		.back_main_o    (b_back)
	);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strap_meta_reg <= 2'h0;
			strap_s_reg    <= 2'h0;
			align_meta_reg <= 1'b1;
			align_s_reg    <= 1'b1;
		end
		else
		begin
			strap_meta_reg <= strap_level_i;
			strap_s_reg    <= strap_meta_reg;
			align_meta_reg <= align_pin_n_i;
			align_s_reg    <= align_meta_reg;
		end
	end

	// ----------------------------------------
	// target address
	// ----------------------------------------
	always_comb
	begin
		unique case (strap_s_reg)
			`STRAP_IN_MID:  strap_bits = `STRAP_BITS_MID;
			`STRAP_IN_HIGH: strap_bits = `STRAP_BITS_HIGH;
			default:        strap_bits = `STRAP_BITS_LOW;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strap_wait_reg <= 2'h0;
			strap_cap_reg  <= 1'b0;
		end
		else
		begin
			if (strap_wait_reg != `STRAP_SETTLE)
				strap_wait_reg <= strap_wait_reg + 2'h1;
			strap_cap_reg <= (strap_wait_reg + 2'h1 == `STRAP_SETTLE);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			target_addr_reg <= `TARGET_ADDR_RST;
		else
		begin
			if (nv_valid_i & nv_fetch_o)
				target_addr_reg[7:3] <= nv_addr_hi_i;
			if (strap_cap_reg)
				target_addr_reg[2:1] <= strap_bits;
			target_addr_reg[0] <= 1'b0;
		end
	end

	// ----------------------------------------
	// image revision reload, request wins over completion
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			nv_fetch_o    <= 1'b1;
			image_rev_reg <= `IMAGE_REV_RST;
		end
		else
		begin
			nv_fetch_o <= nv_commit_i | (nv_fetch_o & ~nv_valid_i);
			if (nv_valid_i & nv_fetch_o)
				image_rev_reg <= nv_rev_i;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			ctl_reg <= `DEVICE_CONTROL_RST;
		else if (ctl_wr)
			ctl_reg <= reg_wdata_i & `DEVICE_CONTROL_WMASK;
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`IDX_TARGET_ADDR: reg_rdata_o <= target_addr_reg;
				`IDX_IMAGE_REV:   reg_rdata_o <= image_rev_reg;
				`IDX_DEVICE_CONTROL:     reg_rdata_o <= ctl_reg;
				`IDX_LIVE_STATUS: reg_rdata_o <= live_reg;
				default:          reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// startup sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			seq_state     <= seq_wait;
			boot_reg      <= 1'b1;
			b_started_reg <= 1'b0;
			align_cnt_reg <= 4'h0;
		end
		else if (soft_hold)
		begin
			seq_state     <= seq_wait;
			boot_reg      <= 1'b1;
			b_started_reg <= 1'b0;
			align_cnt_reg <= 4'h0;
		end
		else
		begin
			unique case (seq_state)
				seq_wait:
				begin
					if (start_go)
					begin
						seq_state <= seq_locking;
						boot_reg  <= 1'b0;
					end
				end
				seq_locking:
				begin
					if (b_go)
						b_started_reg <= 1'b1;
					if (both_ready)
					begin
						if (ctl_reg[`CTL_AUTO_ALIGN])
						begin
							seq_state     <= seq_align;
							align_cnt_reg <= 4'(ALIGN_LEN - 1);
						end
						else
							seq_state <= seq_run;
					end
				end
				seq_align:
				begin
					if (align_cnt_reg == 4'h0)
						seq_state <= seq_run;
					else
						align_cnt_reg <= align_cnt_reg - 4'h1;
				end
				seq_run:
				begin
					seq_state <= seq_run;
				end
			endcase
		end
	end

	// ----------------------------------------
	// calibration starts
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cal_start_a_o <= 1'b0;
			cal_start_b_o <= 1'b0;
			b_pd_prev_reg <= 1'b0;
		end
		else
		begin
			cal_start_a_o <= ~soft_hold & start_go & ~pll_a_power_down_i;
			cal_start_b_o <= ~soft_hold & ((b_go & ~pll_b_power_down_i) | b_restart);
			b_pd_prev_reg <= pll_b_power_down_i;
		end
	end

	// ----------------------------------------
	// core outputs
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			core_reset_o   <= 1'b0;
			sysclk_vco_o   <= 1'b0;
			drive_enable_o <= 1'b0;
			align_active_o <= 1'b0;
		end
		else
		begin
			core_reset_o   <= soft_hold;
			sysclk_vco_o   <= ~soft_hold & ~ctl_reg[`CTL_KEEP_BACKUP] & a_locked;
			drive_enable_o <= ~soft_hold & ((seq_state == seq_run) | (seq_state == seq_align))
			                  & ~(align_any & ctl_reg[`CTL_ALIGN_MUTE]);
			align_active_o <= align_any;
		end
	end

	// ----------------------------------------
	// live status and flag edges
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			live_reg      <= 8'h00;
			live_prev_reg <= 8'h00;
			flag_set_o    <= 8'h00;
		end
		else
		begin
			live_reg      <= {a_lol, a_los, a_cal, b_lol, b_los, b_cal, a_back, b_back};
			live_prev_reg <= live_reg;
			flag_set_o    <= (flag_polarity_i & live_reg & ~live_prev_reg)
			                 | (~flag_polarity_i & ~live_reg & live_prev_reg);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	addr_bit_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!target_addr_reg[0]) else $error("target address bit 0 not zero");
	strap_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		strap_cap_reg && strap_s_reg == `STRAP_IN_HIGH |=> target_addr_reg[2:1] == `STRAP_BITS_HIGH)
		else $error("strap high not mapped to 3");
	rev_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
		nv_fetch_o && nv_valid_i |=> image_rev_reg == $past(nv_rev_i))
		else $error("revision not reloaded from image");
	commit_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		nv_commit_i |=> nv_fetch_o) else $error("commit did not request image fetch");
	soft_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		soft_hold |=> core_reset_o && seq_state == seq_wait) else $error("soft reset not applied");
	soft_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl_reg[`CTL_SOFT_ALIGN] |=> align_active_o) else $error("soft align not active");
	auto_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!soft_hold && seq_state == seq_locking && both_ready && ctl_reg[`CTL_AUTO_ALIGN]
		|=> seq_state == seq_align ##ALIGN_LEN seq_state == seq_run) else $error("auto align sequence wrong");
	mute_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(align_any && ctl_reg[`CTL_ALIGN_MUTE]) |-> !drive_enable_o) else $error("drivers not muted");
	keep_backup_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl_reg[`CTL_KEEP_BACKUP] |=> !sysclk_vco_o) else $error("system clock left backup");
	parallel_cal_a: assert property (@(posedge clk_i) disable iff (rst_i)
		start_go && !soft_hold && ctl_reg[`CTL_CAL_ORDER] && !pll_b_power_down_i
		&& !pll_a_power_down_i |=> cal_start_a_o ##2 cal_start_b_o)
		else $error("parallel calibration not started");
	hold_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl_reg[`CTL_CAL_ORDER] && !a_ready && !b_restart |=> !cal_start_b_o)
		else $error("pll b started before pll a ready");
	auto_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		auto_rise && seq_state == seq_wait && !soft_hold |=> seq_state == seq_locking)
		else $error("auto start write ignored");
	flag_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		live_reg[7] && !live_prev_reg[7] && flag_polarity_i[7] |=> flag_set_o[7])
		else $error("rising edge flag missed");
	los_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(live_reg[7] && live_reg[6]) && !(live_reg[4] && live_reg[3])) else $error("lol with los");

	run_reached_c: cover property (@(posedge clk_i) disable iff (rst_i) seq_state == seq_run);
	align_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
		seq_state == seq_align ##1 seq_state == seq_run);
	flag_fall_c: cover property (@(posedge clk_i) disable iff (rst_i) |(flag_set_o & ~flag_polarity_i));
endmodule

/* tb/pll_side_model.sv */
// Purpose: far side model: two PLLs and the image loader
// Assumes: commands from the bench change at the falling edge
// Notes: lock follows calibration done and input presence
`timescale 1ns/1ns
module pll_side_model
#(
	parameter int CAL_LEN = 20
)
(
	// clock and core hold
	input  wire logic       clk_i,
	input  wire logic       hold_i,
	// device requests
	input  wire logic       cal_start_a_i,
	input  wire logic       cal_start_b_i,
	input  wire logic       nv_fetch_i,
	// bench commands
	input  wire logic [1:0] in_lost_i,
	input  wire logic [1:0] back_main_i,
	input  wire logic [7:0] rev_i,
	// pll status
	output logic      [1:0] lock_o,
	output logic      [1:0] input_ok_o,
	output logic      [1:0] cal_done_o,
	output logic      [1:0] back_main_o,
	// image
	output logic            nv_valid_o,
	output logic      [4:0] nv_addr_hi_o,
	output logic      [7:0] nv_rev_o
);
	int         cnt [2] = '{0, 0};
	int         fw      = 0;
	logic [1:0] go;

	initial
	begin
		cal_done_o = 2'h0;
		nv_valid_o = 1'b0;
	end
	assign go = {cal_start_b_i, cal_start_a_i};
	assign input_ok_o = ~in_lost_i;
	assign lock_o = cal_done_o & ~in_lost_i;
	assign back_main_o = back_main_i;
	assign nv_addr_hi_o = 5'h0a;
	// data only valid with the strobe
	assign nv_rev_o = nv_valid_o ? rev_i : ~rev_i;

	always @(posedge clk_i)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (hold_i)
			begin
				cal_done_o[i] <= 1'b0;
				cnt[i] <= 0;
			end
			else if (go[i])
			begin
				cal_done_o[i] <= 1'b0;
				cnt[i] <= CAL_LEN;
			end
			else if (cnt[i] == 1)
				cal_done_o[i] <= 1'b1;
			if (!hold_i && !go[i] && cnt[i] > 0)
				cnt[i] <= cnt[i] - 1;
		end
		nv_valid_o <= nv_fetch_i && fw == 2;
		fw <= (nv_fetch_i && !nv_valid_o) ? fw + 1 : 0;
	end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench of the control and status bank
// Assumes: register port strobes driven at the falling edge
// Notes: ALIGN_LEN shortened to 2
`timescale 1ns/1ns
module testbench;
	import clockgen_pkg::*;
	localparam int CAL = 20;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic       reg_wr_i = 1'b0;
	logic       reg_rd_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	reg_byte_t  reg_rdata_o;
	logic       nv_commit_i = 1'b0;
	logic       nv_fetch_o;
	logic       align_pin_n_i = 1'b1;
	logic [1:0] strap_level_i = 2'h0;
	logic [7:0] flag_polarity_i = 8'h00;
	logic [7:0] flag_set_o;
	logic       core_reset_o;
	logic       cal_start_a_o;
	logic       cal_start_b_o;
	logic       sysclk_vco_o;
	logic       drive_enable_o;
	logic       align_active_o;
	logic [1:0] in_lost = 2'h0;
	logic [1:0] back_main = 2'h0;
	logic [1:0] pd = 2'h0;
	logic [1:0] lock, in_ok, cal_done, back_o;
	logic [7:0] rev = 8'h00;
	logic [7:0] nv_rev;
	logic [4:0] nv_hi;
	logic       nv_valid;
	logic       seen_al = 1'b0;
	int         err_total = 0;
	int         compares = 0;
	int         cyc = 0, ta = 0, tb = 0, fl6 = 0;

	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	clockgen_ctl #(.ALIGN_LEN(2)) clockgen_ctl_i
	(
		.clk_i,
		.rst_i,
		.reg_addr_i,
		.reg_wr_i,
		.reg_rd_i,
		.reg_wdata_i,
		.reg_rdata_o,
		.nv_commit_i,
		.nv_valid_i         (nv_valid),
		.nv_addr_hi_i       (nv_hi),
		.nv_rev_i           (nv_rev),
		.nv_fetch_o,
		.align_pin_n_i,
		.strap_level_i,
		.pll_a_lock_i       (lock[0]),
		.pll_a_input_ok_i   (in_ok[0]),
		.pll_a_cal_done_i   (cal_done[0]),
		.pll_a_back_main_i  (back_o[0]),
		.pll_a_power_down_i (pd[0]),
		.pll_b_lock_i       (lock[1]),
		.pll_b_input_ok_i   (in_ok[1]),
		.pll_b_cal_done_i   (cal_done[1]),
		.pll_b_back_main_i  (back_o[1]),
		.pll_b_power_down_i (pd[1]),
		.flag_polarity_i,
		.flag_set_o,
		.core_reset_o,
		.cal_start_a_o,
		.cal_start_b_o,
		.sysclk_vco_o,
		.drive_enable_o,
		.align_active_o
	);
	pll_side_model #(.CAL_LEN(CAL)) pll_side_model_i
	(
		.clk_i,
		.hold_i        (rst_i | core_reset_o),
		.cal_start_a_i (cal_start_a_o),
		.cal_start_b_i (cal_start_b_o),
		.nv_fetch_i    (nv_fetch_o),
		.in_lost_i     (in_lost),
		.back_main_i   (back_main),
		.rev_i         (rev),
		.lock_o        (lock),
		.input_ok_o    (in_ok),
		.cal_done_o    (cal_done),
		.back_main_o   (back_o),
		.nv_valid_o    (nv_valid),
		.nv_addr_hi_o  (nv_hi),
		.nv_rev_o      (nv_rev)
	);

	initial
		forever #4 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cal_start_a_o === 1'b1)
			ta <= cyc;
		if (cal_start_b_o === 1'b1)
			tb <= cyc;
		if (align_active_o === 1'b1)
			seen_al <= 1'b1;
		if (flag_set_o[6] === 1'b1)
			fl6 <= fl6 + 1;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test;
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic run(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	task automatic do_reset(input logic [1:0] s);
		@(negedge clk_i);
		rst_i = 1'b1;
		strap_level_i = s;
		run(20);
		rst_i = 1'b0;
		run(60);
	endtask

	task automatic soft_restart(input logic [7:0] c);
		seen_al = 1'b0;
		wr(8'h0c, c & 8'h7f);
		run(2);
		chk(core_reset_o, 1'b1);
		rchk(8'h0c, c & 8'h5f);
		wr(8'h0c, c);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_strap;
		logic [7:0] ea [3] = '{8'h50, 8'h52, 8'h56};
		for (int s = 0; s < 3; s++)
		begin
			rev = 8'h10 + 8'(s);
			do_reset(2'(s));
			rchk(8'h0a, ea[s]);
			rchk(8'h0b, 8'h10 + 8'(s));
		end
	endtask

	task automatic t_regs;
		rchk(8'h0c, 8'hd9);
		rchk(8'h0d, 8'h00);
		wr(8'h0a, 8'hff);
		wr(8'h0b, 8'hff);
		wr(8'h0d, 8'hff);
		rchk(8'h0a, 8'h56);
		rchk(8'h0b, 8'h12);
		rchk(8'h20, 8'h00);
		wr(8'h0c, 8'hfb);
		rchk(8'h0c, 8'hdb);
		rev = 8'ha5;
		@(negedge clk_i);
		nv_commit_i = 1'b1;
		@(negedge clk_i);
		nv_commit_i = 1'b0;
		run(10);
		rchk(8'h0b, 8'ha5);
	endtask

	task automatic t_order;
		logic [7:0] d;
		soft_restart(8'hdb);
		run(5);
		rd(8'h0d, d);
		chk(d & 8'h24, 8'h24);
		run(60);
		chk(8'(tb - ta), 8'h02);
		chk(sysclk_vco_o, 1'b1);
		chk(seen_al, 1'b1);
		soft_restart(8'hc9);
		run(80);
		chk(tb - ta > CAL, 1'b1);
		chk(seen_al, 1'b0);
		chk(drive_enable_o, 1'b1);
		soft_restart(8'hdd);
		run(80);
		chk(sysclk_vco_o, 1'b0);
	endtask

	task automatic t_nostart;
		soft_restart(8'hd8);
		run(40);
		chk(drive_enable_o, 1'b0);
		wr(8'h0c, 8'hd9);
		run(80);
		chk(drive_enable_o, 1'b1);
	endtask

	task automatic t_align;
		wr(8'h0c, 8'h99);
		run(4);
		chk({align_active_o, drive_enable_o}, 2'b10);
		wr(8'h0c, 8'h91);
		run(4);
		chk({align_active_o, drive_enable_o}, 2'b11);
		wr(8'h0c, 8'hd1);
		align_pin_n_i = 1'b0;
		run(6);
		chk({align_active_o, drive_enable_o}, 2'b11);
		align_pin_n_i = 1'b1;
		wr(8'h0c, 8'hd9);
		run(10);
		chk(align_active_o, 1'b0);
	endtask

	task automatic t_live;
		flag_polarity_i = 8'h40;
		fl6 = 0;
		in_lost = 2'b01;
		run(10);
		rchk(8'h0d, 8'h40);
		flag_polarity_i = 8'h00;
		in_lost = 2'b10;
		run(10);
		rchk(8'h0d, 8'h08);
		chk(8'(fl6), 8'h02);
		in_lost = 2'b00;
		back_main = 2'b11;
		run(10);
		rchk(8'h0d, 8'h03);
		back_main = 2'b00;
	endtask

	task automatic t_power;
		int t0;
		wr(8'h0c, 8'hdb);
		t0 = cyc;
		pd[1] = 1'b1;
		run(3);
		pd[1] = 1'b0;
		run(3);
		chk(tb > t0, 1'b1);
		wr(8'h0c, 8'hd9);
		t0 = cyc;
		pd[1] = 1'b1;
		run(3);
		pd[1] = 1'b0;
		run(3);
		chk(tb < t0, 1'b1);
		pd[0] = 1'b1;
		t0 = cyc;
		soft_restart(8'hc9);
		run(10);
		chk(tb > t0 && ta < t0, 1'b1);
		pd[0] = 1'b0;
	endtask

	initial
	begin
		t_strap;
		t_regs;
		t_order;
		t_nostart;
		t_align;
		t_live;
		t_power;
		end_of_test;
	end

	initial
	begin
		#100000;
		err_total++;
		end_of_test;
	end
endmodule
